//--- strap_params.svh
// Timing, reset and field constants for the reset and strap block
`ifndef STRAP_PARAMS_SVH
`define STRAP_PARAMS_SVH
`define CLK_PERIOD_NS 50
`define RESET_MIN_NS 1000
`define RESET_MIN_CYCLES ((`RESET_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ADDR_W 5
`define ADDR_LSB 0
`define ADDR_DEFAULT 5'h01
`define ADDR_ISOLATE 5'h00
`define CNT_W 5
`endif

//--- strap_pkg.sv
// Types shared by the reset and strap block
package strap_pkg;
    typedef struct packed {
        logic [4:0] station_address;
        logic isolate;
    } strap_cfg_t;

    typedef struct packed {
        logic col;
        logic [3:0] rxd;
    } mii_out_t;

    typedef enum logic [2:0] {
        ST_RESET = 3'b001,
        ST_HOLD = 3'b010,
        ST_RUN = 3'b100
    } seq_state_t;
endpackage

//--- reset_sync.sv
// Two-stage reset synchroniser
`timescale 1ns/1ns
module reset_sync (
    input wire logic clk,
    input wire logic rst_n,
    output logic rst_sync_n
);
    logic meta_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            meta_r <= 1'b1;
            rst_sync_n <= meta_r;
        end
    end
endmodule // reset_sync

//--- reset_powerdown_strap_latch.sv
// Reset sequencing, power-down/interrupt pin and station address straps
`timescale 1ns/1ns
`include "strap_params.svh"
module reset_powerdown_strap_latch (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [4:0] station_address_strap_i,
    input wire logic [4:0] station_address_strap_oe_pull,
    input wire strap_pkg::mii_out_t mii_data,
    input wire logic irq_mode_wr,
    input wire logic irq_mode_val,
    input wire logic addr_wr,
    input wire logic [4:0] addr_wr_val,
    input wire logic irq_pending,
    input wire logic powerdown_or_irq_pin_i,
    output logic powerdown_or_irq_pin_o,
    output logic powerdown_or_irq_pin_oe,
    output strap_pkg::mii_out_t mii_pin_o,
    output logic mii_pin_oe,
    output logic [4:0] port_control_register,
    output logic mii_isolate,
    output logic power_down,
    output logic irq_mode,
    output logic device_ready
);
    logic rst_sync_n;
    logic [4:0] strap_eff;
    logic [`CNT_W-1:0] lo_cnt_r;
    logic reset_long_r;
    strap_pkg::seq_state_t state_r;
    strap_pkg::seq_state_t state_nxt;
    strap_pkg::strap_cfg_t cfg_r;
    localparam logic [4:0] addr_pull = `ADDR_DEFAULT;

    reset_sync u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .rst_sync_n(rst_sync_n)
    );

    // Undriven straps fall to the internal pulls: bit 0 up, others down
    always_comb begin
        for (int i = 0; i < 5; i++) begin
            strap_eff[i] = station_address_strap_oe_pull[i] ?
                station_address_strap_i[i] : addr_pull[i];
        end
    end

    // Counts reset-low cycles up to RESET_MIN_CYCLES; nothing reads the count
    always_ff @(posedge clk) begin
        if (rst_n) begin
            lo_cnt_r <= '0;
        end else if (lo_cnt_r != `CNT_W'(`RESET_MIN_CYCLES)) begin
            lo_cnt_r <= lo_cnt_r + `CNT_W'(1);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reset_long_r <= 1'b0;
        end else begin
            reset_long_r <= 1'b1;
        end
    end

    always_comb begin
        case (state_r)
            strap_pkg::ST_RESET: state_nxt = strap_pkg::ST_HOLD;
            strap_pkg::ST_HOLD: state_nxt = strap_pkg::ST_RUN;
            strap_pkg::ST_RUN: state_nxt = strap_pkg::ST_RUN;
            default: state_nxt = strap_pkg::ST_RESET;
        endcase
    end

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            state_r <= strap_pkg::ST_RESET;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Straps captured on the first clock after synchronised release
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            cfg_r <= '{station_address: `ADDR_DEFAULT, isolate: 1'b0};
        end else if (state_r == strap_pkg::ST_RESET) begin
            cfg_r.station_address <= strap_eff;
            cfg_r.isolate <= (strap_eff == `ADDR_ISOLATE);
        end
    end

    // Address field: strapped value, software may rewrite it
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            port_control_register <= `ADDR_DEFAULT;
        end else if (state_r == strap_pkg::ST_RESET) begin
            port_control_register <= strap_eff;
        end else if (addr_wr && state_r == strap_pkg::ST_RUN) begin
            port_control_register <= addr_wr_val;
        end
    end

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            mii_isolate <= 1'b0;
        end else if (state_r == strap_pkg::ST_HOLD) begin
            mii_isolate <= cfg_r.isolate;
        end
    end

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            irq_mode <= 1'b0;
        end else if (irq_mode_wr && state_r == strap_pkg::ST_RUN) begin
            irq_mode <= irq_mode_val;
        end
    end

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            power_down <= 1'b0;
            powerdown_or_irq_pin_o <= 1'b0;
            powerdown_or_irq_pin_oe <= 1'b0;
        end else begin
            power_down <= !irq_mode && !powerdown_or_irq_pin_i;
            powerdown_or_irq_pin_o <= 1'b0;
            powerdown_or_irq_pin_oe <= irq_mode && irq_pending;
        end
    end

    // Strap pins become MII outputs only after capture
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            mii_pin_oe <= 1'b0;
            mii_pin_o <= '0;
            device_ready <= 1'b0;
        end else begin
            mii_pin_oe <= (state_r == strap_pkg::ST_RUN) &&
                !cfg_r.isolate;
            mii_pin_o <= mii_data;
            device_ready <= (state_r == strap_pkg::ST_RUN);
        end
    end

    strap_when_reset_a: assert property (@(posedge clk)
        disable iff (!rst_n)
        $rose(rst_sync_n) |->
        ##1 port_control_register == $past(strap_eff))
        else $error("Strap not latched");

    isolate_from_strap_a: assert property (@(posedge clk)
        disable iff (!rst_sync_n)
        (state_r == strap_pkg::ST_HOLD) |=>
        mii_isolate == (port_control_register == 5'h00))
        else $error("Isolate mismatch");

    no_isolate_write_a: assert property (@(posedge clk)
        disable iff (!rst_sync_n)
        (state_r == strap_pkg::ST_RUN && $stable(state_r)) |=>
        $stable(mii_isolate))
        else $error("Isolate changed by write");

    irq_drive_a: assert property (@(posedge clk)
        disable iff (!rst_sync_n)
        (irq_mode && irq_pending) |=>
        powerdown_or_irq_pin_oe && !powerdown_or_irq_pin_o)
        else $error("Interrupt not driven");

    pd_input_a: assert property (@(posedge clk)
        disable iff (!rst_sync_n)
        !irq_mode |=>
        !powerdown_or_irq_pin_oe)
        else $error("Pin driven in power-down mode");

    power_down_a: assert property (@(posedge clk)
        disable iff (!rst_sync_n)
        (!irq_mode && !powerdown_or_irq_pin_i) |=>
        power_down)
        else $error("Power-down missed");

    strap_then_out_a: assert property (@(posedge clk)
        disable iff (!rst_sync_n)
        mii_pin_oe |->
        state_r == strap_pkg::ST_RUN)
        else $error("Outputs before capture");

    default_addr_a: assert property (@(posedge clk)
        disable iff (!rst_sync_n)
        (state_r == strap_pkg::ST_RESET &&
        station_address_strap_oe_pull == 5'h00) |=>
        cfg_r.station_address == 5'h01)
        else $error("Default address wrong");

    ready_in_run_a: assert property (@(posedge clk)
        disable iff (!rst_sync_n)
        device_ready |->
        state_r == strap_pkg::ST_RUN)
        else $error("Ready outside run");

    irq_release_a: assert property (@(posedge clk)
        disable iff (!rst_sync_n)
        (!irq_mode || !irq_pending) |=>
        !powerdown_or_irq_pin_oe)
        else $error("Interrupt pin not released");

    power_up_a: assert property (@(posedge clk)
        disable iff (!rst_sync_n)
        (irq_mode || powerdown_or_irq_pin_i) |=>
        !power_down)
        else $error("Power-down without request");

    irq_reset_default_a: assert property (@(posedge clk)
        disable iff (!rst_sync_n)
        (state_r == strap_pkg::ST_RESET) |->
        !irq_mode)
        else $error("Interrupt function after reset");

    cfg_stable_a: assert property (@(posedge clk)
        disable iff (!rst_sync_n)
        (state_r != strap_pkg::ST_RESET) |=>
        $stable(cfg_r))
        else $error("Strap configuration changed");

    hold_after_reset_a: assert property (@(posedge clk)
        disable iff (!rst_sync_n)
        (state_r == strap_pkg::ST_RESET) |=>
        state_r == strap_pkg::ST_HOLD)
        else $error("Capture step skipped");

    run_after_hold_a: assert property (@(posedge clk)
        disable iff (!rst_sync_n)
        (state_r == strap_pkg::ST_HOLD) |=>
        state_r == strap_pkg::ST_RUN)
        else $error("Run state not reached");

    isolate_quiet_a: assert property (@(posedge clk)
        disable iff (!rst_sync_n)
        mii_isolate |->
        !mii_pin_oe)
        else $error("Outputs driven in isolate");

    addr_write_a: assert property (@(posedge clk)
        disable iff (!rst_sync_n)
        (addr_wr && state_r == strap_pkg::ST_RUN) |=>
        port_control_register == $past(addr_wr_val))
        else $error("Address write lost");

    no_early_write_a: assert property (@(posedge clk)
        disable iff (!rst_sync_n)
        (state_r == strap_pkg::ST_HOLD) |=>
        $stable(port_control_register))
        else $error("Address changed before run");

    irq_write_a: assert property (@(posedge clk)
        disable iff (!rst_sync_n)
        (irq_mode_wr && state_r == strap_pkg::ST_RUN) |=>
        irq_mode == $past(irq_mode_val))
        else $error("Interrupt select lost");

    irq_hold_a: assert property (@(posedge clk)
        disable iff (!rst_sync_n)
        (!irq_mode_wr || state_r != strap_pkg::ST_RUN) |=>
        $stable(irq_mode))
        else $error("Interrupt select without write");

    strap_bits_a: assert property (@(posedge clk)
        disable iff (!rst_sync_n)
        (state_r == strap_pkg::ST_RESET) |=>
        cfg_r.station_address == $past(strap_eff))
        else $error("Strap bits misplaced");

    strap_pull_a: assert property (@(posedge clk)
        disable iff (!rst_sync_n)
        (state_r == strap_pkg::ST_RESET &&
        !station_address_strap_oe_pull[0]) |=>
        port_control_register[0])
        else $error("Address bit 0 pull missed");

    mii_follow_a: assert property (@(posedge clk)
        disable iff (!rst_sync_n)
        (state_r == strap_pkg::ST_RUN) |=>
        mii_pin_o == $past(mii_data))
        else $error("Output data not forwarded");

    ready_oe_a: assert property (@(posedge clk)
        disable iff (!rst_sync_n)
        device_ready |->
        mii_pin_oe == !mii_isolate)
        else $error("Output enable wrong when ready");
endmodule // reset_powerdown_strap_latch

//--- host_model.sv
// Host side model: drives reset and resolves the shared open-drain pin
`timescale 1ns/1ns
module host_model (
    input wire logic clk,
    input wire logic pd_low,
    input wire logic pin_oe,
    output logic rst_n,
    output logic pin
);
    initial rst_n = 1'b0;
    // Either party pulls low, the pull-up holds it high otherwise
    assign pin = (pin_oe || pd_low) ? 1'b0 : 1'b1;
    // Reset low for n cycles, changed at the falling edge
    task pulse(input int n);
        @(negedge clk);
        rst_n = 1'b0;
        repeat (n) @(negedge clk);
        rst_n = 1'b1;
    endtask
endmodule // host_model

//--- tb.sv
// Self-checking bench for the reset, power-down and strap block
`timescale 1ns/1ns
module tb;
    logic clk = 1'b0;
    logic [4:0] strap_i = 5'h00, oe_pull = 5'h00, addr_wr_val = 5'h00;
    strap_pkg::mii_out_t mii_data = '0;
    logic irq_mode_wr = 0, irq_mode_val = 0, addr_wr = 0;
    logic irq_pending = 0, pd_low = 0;
    logic rst_n, pin, pin_o, pin_oe, mii_oe, iso, pd, irqm, ready;
    strap_pkg::mii_out_t mii_o;
    logic [4:0] pcr;
    logic [31:0] lfsr = 32'h401d4ac2;
    logic [5:0] notes[$];
    logic [5:0] n;
    int fail_count = 0;
    int samples_checked = 0;
    always #25 clk = ~clk;
    host_model host (.clk(clk), .pd_low(pd_low), .pin_oe(pin_oe),
        .rst_n(rst_n), .pin(pin));
    reset_powerdown_strap_latch uut (.clk(clk), .rst_n(rst_n),
        .station_address_strap_i(strap_i),
        .station_address_strap_oe_pull(oe_pull), .mii_data(mii_data),
        .irq_mode_wr(irq_mode_wr), .irq_mode_val(irq_mode_val),
        .addr_wr(addr_wr), .addr_wr_val(addr_wr_val),
        .irq_pending(irq_pending), .powerdown_or_irq_pin_i(pin),
        .powerdown_or_irq_pin_o(pin_o), .powerdown_or_irq_pin_oe(pin_oe),
        .mii_pin_o(mii_o), .mii_pin_oe(mii_oe), .port_control_register(pcr),
        .mii_isolate(iso), .power_down(pd), .irq_mode(irqm),
        .device_ready(ready));
    function automatic logic [31:0] next_rand(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    task chk(input string name, input logic [5:0] e, input logic [5:0] g);
        samples_checked++;
        if (g !== e) begin
            $display("Error %s expected %h seen %h", name, e, g);
            fail_count++;
        end
    endtask
    task give_verdict;
        $display("fail_count %0d samples_checked %0d", fail_count,
            samples_checked);
        if (fail_count == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // Reset with given straps; expected address and isolate go in the queue
    task strap_reset(input logic [4:0] s, input logic [4:0] p, input int len);
        logic [4:0] e;
        @(negedge clk);
        strap_i = s;
        oe_pull = p;
        for (int i = 0; i < 5; i++)
            e[i] = p[i] ? s[i] : (i == 0);
        notes.push_back({e == 5'h00, e});
        host.pulse(len);
        for (int i = 0; i < 20 && !ready; i++)
            @(negedge clk);
    endtask
    // Watcher: each rise of ready is compared with the oldest note
    always @(posedge ready) begin
        #1;
        n = notes.size() ? notes.pop_front() : 6'h3f;
        chk("address", {1'b0, n[4:0]}, {1'b0, pcr});
        chk("isolate", {5'h00, n[5]}, {5'h00, iso});
        chk("mii_oe", {5'h00, !n[5]}, {5'h00, mii_oe});
    end
    initial begin
        #(4000 * 50);
        fail_count++;
        give_verdict;
    end
    initial begin
        strap_reset(5'h1a, 5'h00, 12);
        for (int k = 0; k < 6; k++) begin
            lfsr = next_rand(lfsr);
            strap_reset(k == 1 ? 5'h00 : (k == 2 ? 5'h1f : lfsr[4:0]),
                k < 3 ? 5'h1f : lfsr[9:5], 20);
        end
        strap_reset(5'h05, 5'h1f, 20);
        mii_data = lfsr[14:10];
        addr_wr = 1'b1;
        addr_wr_val = 5'h00;
        @(negedge clk);
        addr_wr = 1'b0;
        @(negedge clk);
        chk("addr_write", 6'h00, {1'b0, pcr});
        chk("mii_data", {1'b0, lfsr[14:10]}, {1'b0, mii_o});
        chk("no_isolate", 6'h00, {5'h00, iso});
        chk("irq_default", 6'h00, {5'h00, irqm});
        pd_low = 1'b1;
        repeat (4) @(negedge clk);
        chk("power_down", 6'h01, {5'h00, pd});
        pd_low = 1'b0;
        repeat (4) @(negedge clk);
        chk("power_up", 6'h00, {5'h00, pd});
        irq_mode_wr = 1'b1;
        irq_mode_val = 1'b1;
        @(negedge clk);
        irq_mode_wr = 1'b0;
        irq_pending = 1'b1;
        repeat (3) @(negedge clk);
        chk("irq_pull", 6'h02, {4'h0, pin_oe, pin_o});
        irq_pending = 1'b0;
        repeat (3) @(negedge clk);
        chk("irq_release", 6'h00, {5'h00, pin_oe});
        irq_pending = 1'b1;
        strap_reset(5'h00, 5'h00, 20);
        chk("irq_after_reset", 6'h00, {4'h0, irqm, pin_oe});
        chk("notes_left", 6'h00, 6'(notes.size()));
        give_verdict;
    end
endmodule // tb
